// File: src/eic_pkg.sv
// package: control register map, field layout and exception codes
package eic_pkg;
    // control register indices on the control-register port
    localparam logic [4:0] CTL_TLB_MISC = 5'h0a;
    localparam logic [4:0] CTL_FAULT_ADDR = 5'h0c;
    localparam logic [4:0] CTL_RUNTIME_CFG = 5'h0d;

    // tlb miscellaneous register fields
    localparam int MISC_DATA_SIDE_BIT = 0;
    localparam int MISC_VIOLATION_BIT = 1;
    localparam int MISC_BAD_VADDR_BIT = 2;
    localparam int MISC_DOUBLE_MISS_BIT = 3;
    localparam int MISC_TAG_LSB = 4;
    localparam int MISC_TAG_MAX = 14;
    localparam int MISC_TAG_MIN = 8;
    localparam int MISC_READ_TRIGGER_BIT = 19;

    // runtime configuration fields
    localparam int CFG_PROTECT_BIT = 0;
    localparam int CFG_ECC_EN_BIT = 1;
    localparam int CFG_ECC_EXC_BIT = 2;
    localparam int CFG_AUTO_NEST_BIT = 3;

    localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;
    localparam int BYPASS_BIT = 31;
    localparam int ADDR_FULL = 32;

    // general exception kinds reported by the pipeline
    typedef enum logic [3:0] {
        EIC_EXC_OTHER = 4'h0,
        EIC_EXC_FAST_MISS_INST = 4'h1,
        EIC_EXC_FAST_MISS_DATA = 4'h2,
        EIC_EXC_DOUBLE_MISS_INST = 4'h3,
        EIC_EXC_DOUBLE_MISS_DATA = 4'h4,
        EIC_EXC_VIOLATION_FLAG_A_EXEC = 4'h5,
        EIC_EXC_VIOLATION_FLAG_A_READ = 4'h6,
        EIC_EXC_VIOLATION_FLAG_A_WRITE = 4'h7,
        EIC_EXC_MISALIGN_DATA = 4'h8,
        EIC_EXC_MISALIGN_DEST = 4'h9,
        EIC_EXC_SUPER_INST = 4'ha,
        EIC_EXC_SUPER_DATA = 4'hb,
        EIC_EXC_BREAK = 4'hc
    } eic_exc_kind_t;

    // exception event from the pipeline
    typedef struct packed {
        logic taken;
        eic_exc_kind_t kind;
        logic addr_valid;
        logic [31:0] addr;
    } eic_exc_t;

    // control-register access from the instruction stream
    typedef struct packed {
        logic wr;
        logic [4:0] sel;
        logic [31:0] data;
    } eic_ctl_t;

    typedef struct packed {
        logic double_miss_flag;
        logic bad_vaddr_flag;
        logic violation_flag_a;
        logic data_side_flag;
    } eic_flags_t;
endpackage

// File: src/eic_exc_decode.sv
// exception kind decoder: flag values for one general exception
module eic_exc_decode (
    input eic_pkg::eic_exc_kind_t kind,
    output eic_pkg::eic_flags_t flags
);
    always_comb begin
        flags = '0;
        case (kind)
            eic_pkg::EIC_EXC_FAST_MISS_DATA: begin
                flags.data_side_flag = 1'b1;
            end
            eic_pkg::EIC_EXC_DOUBLE_MISS_INST: begin
                flags.double_miss_flag = 1'b1;
            end
            eic_pkg::EIC_EXC_DOUBLE_MISS_DATA: begin
                flags.double_miss_flag = 1'b1;
                flags.data_side_flag = 1'b1;
            end
            eic_pkg::EIC_EXC_VIOLATION_FLAG_A_EXEC: begin
                flags.violation_flag_a = 1'b1;
            end
            eic_pkg::EIC_EXC_VIOLATION_FLAG_A_READ, eic_pkg::EIC_EXC_VIOLATION_FLAG_A_WRITE: begin
                flags.violation_flag_a = 1'b1;
                flags.data_side_flag = 1'b1;
            end
            eic_pkg::EIC_EXC_MISALIGN_DATA,
            eic_pkg::EIC_EXC_SUPER_DATA: begin
                flags.bad_vaddr_flag = 1'b1;
                flags.data_side_flag = 1'b1;
            end
            eic_pkg::EIC_EXC_MISALIGN_DEST,
            eic_pkg::EIC_EXC_SUPER_INST: begin
                flags.bad_vaddr_flag = 1'b1;
            end
            default: begin
                flags = '0;
            end
        endcase
    end
endmodule

// File: src/eic_addr_mask.sv
// fault address shaping for narrow or unmapped configurations
module eic_addr_mask #(
    parameter int ADDR_BITS = 32,
    parameter bit HAS_MMU = 1'b1,
    parameter bit HAS_MPU = 1'b0
) (
    input wire logic [31:0] addr_in,
    input wire logic is_data,
    output logic [31:0] addr_out
);
    localparam int KEEP = (HAS_MMU || HAS_MPU) ? eic_pkg::ADDR_FULL
        : ADDR_BITS;
    localparam logic [31:0] KEEP_MASK = (KEEP >= 32) ? 32'hffff_ffff
        : ((32'h0000_0001 << KEEP) - 32'h0000_0001);

    if (ADDR_BITS < 1 || ADDR_BITS > eic_pkg::ADDR_FULL) begin : g_width
        $error("address width out of range");
    end

    always_comb begin
        addr_out = addr_in & KEEP_MASK;
        // cache bypass bit has no meaning without translation
        if (!HAS_MMU && is_data) begin
            addr_out[eic_pkg::BYPASS_BIT] = 1'b0;
        end
    end
endmodule

// File: src/eic_regs.sv
// exception info and runtime configuration control registers
// Summary of operation
// - process tag width is 8 to 14 bits
// - tlb read tag beats same control write
// - double miss flag set or cleared each exception
// - bad address flag for four listed exceptions
// - violation flag set only on permission violation
// - data flag for data exceptions, non-break clears
// - six listed exceptions set data flag
// - extra info forced on with mmu or mpu
// - listed exceptions capture fault address
// - full 32-bit virtual address with mmu/mpu
// - unused high address bits stay zero
// - bypass bit zero on data-side addresses without mmu
// - auto nest bit keeps prev enable set
// - auto nest reads zero without eic/shadow
// - ecc exceptions only when enabled, reset zero
// - ecc enable ignores or recovers errors
// - protection bit enables mpu, zero without it
// - tlb read loads tag from selected entry
module eic_regs #(
    parameter int TAG_BITS = 8,
    parameter int ADDR_BITS = 32,
    parameter bit HAS_MMU = 1'b1,
    parameter bit HAS_MPU = 1'b0,
    parameter bit EXTRA_INFO_OPT = 1'b0,
    parameter bit HAS_ECC = 1'b1,
    parameter bit HAS_EXT_IRQ_SHADOW = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input eic_pkg::eic_ctl_t ctl,
    output logic [31:0] ctl_rdata,
    input eic_pkg::eic_exc_t exc,
    output logic tlb_read_req,
    input wire logic [TAG_BITS-1:0] tlb_entry_tag,
    input wire logic irq_entry,
    input wire logic status_ie,
    output logic prev_interrupt_enable,
    input wire logic ecc_error,
    input wire logic ecc_recoverable,
    output logic ecc_exception_req,
    output logic ecc_recover_req,
    output logic protection_on,
    output logic ecc_ignore,
    output eic_pkg::eic_flags_t flags_out,
    output logic [31:0] fault_address
);
    localparam bit EXTRA_INFO = HAS_MMU || HAS_MPU || EXTRA_INFO_OPT;
    localparam int TL = eic_pkg::MISC_TAG_LSB;

    // elaboration checks: refuse what the field layout cannot hold
    if (TAG_BITS < eic_pkg::MISC_TAG_MIN ||
        TAG_BITS > eic_pkg::MISC_TAG_MAX) begin : g_tag_width
        $error("process tag width must be 8 to 14");
    end
    // a wider tag would run into the read trigger bit
    if (TL + TAG_BITS > eic_pkg::MISC_READ_TRIGGER_BIT) begin : g_tag_room
        $error("process tag overlaps the read trigger");
    end
    if (ADDR_BITS < 1 || ADDR_BITS > eic_pkg::ADDR_FULL) begin : g_addr
        $error("address width must be 1 to 32");
    end
    // translated and protected addresses are always full width
    if ((HAS_MMU || HAS_MPU) &&
        ADDR_BITS != eic_pkg::ADDR_FULL) begin : g_full
        $error("mmu or mpu needs a 32-bit address space");
    end

    eic_pkg::eic_flags_t dec_flags;
    logic [31:0] masked_addr;

    eic_exc_decode u_decode (
        .kind(exc.kind),
        .flags(dec_flags)
    );

    eic_addr_mask #(
        .ADDR_BITS(ADDR_BITS),
        .HAS_MMU(HAS_MMU),
        .HAS_MPU(HAS_MPU)
    ) u_mask (
        .addr_in(exc.addr),
        .is_data(dec_flags.data_side_flag),
        .addr_out(masked_addr)
    );

    logic [TAG_BITS-1:0] process_tag_reg;
    logic [TAG_BITS-1:0] process_tag_next;
    eic_pkg::eic_flags_t flags_reg;
    eic_pkg::eic_flags_t flags_next;
    logic [31:0] fault_addr_reg;
    logic [31:0] fault_addr_next;
    logic auto_nested_reg;
    logic auto_nested_next;
    logic ecc_exc_en_reg;
    logic ecc_exc_en_next;
    logic ecc_en_reg;
    logic ecc_en_next;
    logic protect_reg;
    logic protect_next;
    logic tlb_read_reg;
    logic tlb_read_next;
    logic pie_reg;
    logic pie_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] misc_view;
    logic [31:0] cfg_view;

    logic wr_misc;
    logic wr_cfg;
    logic read_trig;
    logic exc_is_break;

    // writes decode here; reads use sel alone
    assign wr_misc = ctl.wr && ctl.sel == eic_pkg::CTL_TLB_MISC;
    assign wr_cfg = ctl.wr && ctl.sel == eic_pkg::CTL_RUNTIME_CFG;
    assign read_trig = wr_misc && ctl.data[eic_pkg::MISC_READ_TRIGGER_BIT];
    assign exc_is_break = exc.kind == eic_pkg::EIC_EXC_BREAK;

    // process tag: software write, then tlb read overwrite
    always_comb begin
        process_tag_next = process_tag_reg;
        if (HAS_MMU) begin
            if (wr_misc) begin
                process_tag_next = ctl.data[TL +: TAG_BITS];
            end
            // entry tag arrives the cycle after the trigger, so it
            // overwrites whatever tag the triggering write carried
            if (tlb_read_reg) begin
                process_tag_next = tlb_entry_tag;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            process_tag_reg <= '0;
        end else begin
            process_tag_reg <= process_tag_next;
        end
    end

    // tlb read request: one-cycle pulse after the trigger write
    always_comb begin
        tlb_read_next = read_trig;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tlb_read_reg <= 1'b0;
        end else begin
            tlb_read_reg <= tlb_read_next;
        end
    end

    // exception flags; software writes never reach them
    always_comb begin
        flags_next = flags_reg;
        if (exc.taken && HAS_MMU) begin
            flags_next.double_miss_flag = dec_flags.double_miss_flag;
            flags_next.bad_vaddr_flag = dec_flags.bad_vaddr_flag;
            flags_next.violation_flag_a = dec_flags.violation_flag_a;
            // break leaves the data flag as it was
            if (!exc_is_break) begin
                flags_next.data_side_flag = dec_flags.data_side_flag;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // fault address; high and bypass bits are cut in the mask
    always_comb begin
        fault_addr_next = fault_addr_reg;
        if (exc.taken && exc.addr_valid && EXTRA_INFO) begin
            fault_addr_next = masked_addr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_addr_reg <= eic_pkg::FAULT_ADDR_RESET;
        end else begin
            fault_addr_reg <= fault_addr_next;
        end
    end

    // runtime configuration; bits absent by parameter stay zero
    always_comb begin
        auto_nested_next = auto_nested_reg;
        ecc_exc_en_next = ecc_exc_en_reg;
        ecc_en_next = ecc_en_reg;
        protect_next = protect_reg;
        if (wr_cfg) begin
            auto_nested_next = HAS_EXT_IRQ_SHADOW &&
                ctl.data[eic_pkg::CFG_AUTO_NEST_BIT];
            ecc_exc_en_next = HAS_ECC &&
                ctl.data[eic_pkg::CFG_ECC_EXC_BIT];
            ecc_en_next = HAS_ECC && ctl.data[eic_pkg::CFG_ECC_EN_BIT];
            protect_next = HAS_MPU &&
                ctl.data[eic_pkg::CFG_PROTECT_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            auto_nested_reg <= 1'b0;
            ecc_exc_en_reg <= 1'b0;
            ecc_en_reg <= 1'b0;
            protect_reg <= 1'b0;
        end else begin
            auto_nested_reg <= auto_nested_next;
            ecc_exc_en_reg <= ecc_exc_en_next;
            ecc_en_reg <= ecc_en_next;
            protect_reg <= protect_next;
        end
    end

    // previous enable follows the live enable between entries
    always_comb begin
        pie_next = status_ie;
        if (irq_entry) begin
            // fast nesting keeps the previous enable at one
            pie_next = auto_nested_reg ? 1'b1 : 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pie_reg <= 1'b0;
        end else begin
            pie_reg <= pie_next;
        end
    end

    // ecc steering is combinational so the error is acted on at once
    always_comb begin
        ecc_ignore = !ecc_en_reg;
        ecc_recover_req = ecc_en_reg && ecc_error &&
            ecc_recoverable;
        ecc_exception_req = ecc_en_reg && ecc_exc_en_reg &&
            ecc_error;
    end

    assign protection_on = protect_reg;
    assign prev_interrupt_enable = pie_reg;
    assign tlb_read_req = tlb_read_reg;
    assign flags_out = flags_reg;
    assign fault_address = fault_addr_reg;
    assign ctl_rdata = rdata_reg;

    // register images as software sees them
    always_comb begin
        misc_view = 32'h0000_0000;
        misc_view[TL +: TAG_BITS] = process_tag_reg;
        // flag bits only ever change on an exception
        misc_view[eic_pkg::MISC_DOUBLE_MISS_BIT] =
            flags_reg.double_miss_flag;
        misc_view[eic_pkg::MISC_BAD_VADDR_BIT] =
            flags_reg.bad_vaddr_flag;
        misc_view[eic_pkg::MISC_VIOLATION_BIT] =
            flags_reg.violation_flag_a;
        misc_view[eic_pkg::MISC_DATA_SIDE_BIT] =
            flags_reg.data_side_flag;
        cfg_view = 32'h0000_0000;
        cfg_view[eic_pkg::CFG_AUTO_NEST_BIT] = auto_nested_reg;
        cfg_view[eic_pkg::CFG_ECC_EXC_BIT] = ecc_exc_en_reg;
        cfg_view[eic_pkg::CFG_ECC_EN_BIT] = ecc_en_reg;
        cfg_view[eic_pkg::CFG_PROTECT_BIT] = protect_reg;
    end

    // read select
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (ctl.sel)
            eic_pkg::CTL_TLB_MISC: begin
                rdata_next = misc_view;
            end
            eic_pkg::CTL_FAULT_ADDR: begin
                rdata_next = fault_addr_reg;
            end
            eic_pkg::CTL_RUNTIME_CFG: begin
                rdata_next = cfg_view;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // one cycle of read latency buys a flop-driven data output
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
endmodule

// File: bench/eic_regs_chk.sv
// checker: exception flag, fault address and tlb read assertions
module eic_regs_chk #(
    parameter int TAG_BITS = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input eic_pkg::eic_ctl_t ctl,
    input wire logic [31:0] ctl_rdata,
    input eic_pkg::eic_exc_t exc,
    input wire logic tlb_read_req,
    input wire logic [TAG_BITS-1:0] tlb_entry_tag,
    input eic_pkg::eic_flags_t flags_out,
    input wire logic [31:0] fault_address
);
    localparam logic [4:0] MISC = eic_pkg::CTL_TLB_MISC;
    // {double,bad,violation,data} per kind code; break row left zero
    localparam logic [3:0] FT [16] = '{4'h0, 4'h0, 4'h1, 4'h8, 4'h9, 4'h2,
        4'h3, 4'h3, 4'h5, 4'h4, 4'h4, 4'h5, 4'h0, 4'h0, 4'h0, 4'h0};
    logic [3:0] ft;
    logic is_brk;
    logic rd_trig;

    assign ft = FT[exc.kind];
    assign is_brk = exc.kind == eic_pkg::EIC_EXC_BREAK;
    assign rd_trig = ctl.wr && ctl.sel == MISC &&
        ctl.data[eic_pkg::MISC_READ_TRIGGER_BIT];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff rst;

    property p_tlb_req;
        rd_trig |=> tlb_read_req;
    endproperty
    a_tlb_req: assert property (p_tlb_req) else $error("no tlb read");
    // a write in the request cycle is skipped, though the tlb read tag wins over it
    // read data lags sel by one edge
    property p_tag_load;
        (tlb_read_req && !ctl.wr) ##1 ctl.sel == MISC |=>
            ctl_rdata[eic_pkg::MISC_TAG_LSB +: TAG_BITS] ==
            $past(tlb_entry_tag, 2);
    endproperty
    a_tag_load: assert property (p_tag_load) else $error("tag");
    property p_dbl;
        exc.taken |=> flags_out.double_miss_flag == $past(ft[3]);
    endproperty
    a_dbl: assert property (p_dbl) else $error("double flag");
    property p_bad;
        exc.taken |=> flags_out.bad_vaddr_flag == $past(ft[2]);
    endproperty
    a_bad: assert property (p_bad) else $error("bad addr flag");
    property p_violation_flag_a;
        exc.taken |=> flags_out.violation_flag_a == $past(ft[1]);
    endproperty
    a_violation_flag_a: assert property (p_violation_flag_a) else $error("violation flag");
    property p_data;
        exc.taken && !is_brk |=> flags_out.data_side_flag == $past(ft[0]);
    endproperty
    a_data: assert property (p_data) else $error("data flag");
    property p_hold;
        !exc.taken |=> $stable(flags_out);
    endproperty
    a_hold: assert property (p_hold) else $error("flags moved");
    property p_fault;
        exc.taken && exc.addr_valid |=> fault_address == $past(exc.addr);
    endproperty
    a_fault: assert property (p_fault) else $error("fault addr");
endmodule

bind eic_regs eic_regs_chk #(.TAG_BITS(TAG_BITS)) i_eic_regs_chk (
    .ref_clk(ref_clk), .rst(rst), .ctl(ctl), .ctl_rdata(ctl_rdata),
    .exc(exc), .tlb_read_req(tlb_read_req), .tlb_entry_tag(tlb_entry_tag),
    .flags_out(flags_out), .fault_address(fault_address)
);

// File: bench/tb_eic_regs.sv
// testbench: control register and exception capture sequences
module tb_eic_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] MISC = eic_pkg::CTL_TLB_MISC;
    localparam logic [4:0] FLT = eic_pkg::CTL_FAULT_ADDR;
    localparam logic [4:0] CFG = eic_pkg::CTL_RUNTIME_CFG;
    // {double,bad,violation,data} per kind code; break keeps data
    localparam logic [3:0] FT [13] = '{4'h0, 4'h0, 4'h1, 4'h8, 4'h9, 4'h2,
        4'h3, 4'h3, 4'h5, 4'h4, 4'h4, 4'h5, 4'h0};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    eic_pkg::eic_ctl_t ctl = '0;
    eic_pkg::eic_exc_t exc = '0;
    logic [7:0] tlb_entry_tag = 8'h00;
    logic irq_entry = 1'b0;
    logic status_ie = 1'b0;
    logic ecc_error = 1'b0;
    logic ecc_recoverable = 1'b0;
    logic [31:0] ctl_rdata, fault_address;
    logic tlb_read_req, prev_interrupt_enable, ecc_exception_req;
    logic ecc_recover_req, protection_on, ecc_ignore;
    eic_pkg::eic_flags_t flags_out;
    int miscompares = 0;
    int cmp_count = 0;

    always #25 ref_clk = ~ref_clk;

    eic_regs #(.TAG_BITS(8), .HAS_MPU(1'b1)) i_eic_regs (
        .ref_clk(ref_clk), .rst(rst), .ctl(ctl), .ctl_rdata(ctl_rdata),
        .exc(exc), .tlb_read_req(tlb_read_req),
        .tlb_entry_tag(tlb_entry_tag), .irq_entry(irq_entry),
        .status_ie(status_ie),
        .prev_interrupt_enable(prev_interrupt_enable),
        .ecc_error(ecc_error), .ecc_recoverable(ecc_recoverable),
        .ecc_exception_req(ecc_exception_req),
        .ecc_recover_req(ecc_recover_req), .protection_on(protection_on),
        .ecc_ignore(ecc_ignore), .flags_out(flags_out),
        .fault_address(fault_address)
    );

    task automatic chk(input string what, input logic [31:0] got,
        input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] sel, input logic [31:0] data);
        @(posedge ref_clk);
        ctl <= '{wr: 1'b1, sel: sel, data: data};
        @(posedge ref_clk);
        ctl.wr <= 1'b0;
    endtask

    // read data is registered: one edge to present sel, one to capture
    task automatic rd(input logic [4:0] sel, input logic [31:0] exp);
        @(posedge ref_clk);
        ctl.sel <= sel;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk($sformatf("reg %h", sel), ctl_rdata, exp);
    endtask

    task automatic ex(input eic_pkg::eic_exc_kind_t k, input logic [31:0] a);
        @(posedge ref_clk);
        exc <= '{taken: 1'b1, kind: k, addr_valid: 1'b1, addr: a};
        @(posedge ref_clk);
        exc.taken <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic irq(input logic exp);
        @(posedge ref_clk);
        irq_entry <= 1'b1;
        @(posedge ref_clk);
        irq_entry <= 1'b0;
        @(negedge ref_clk);
        chk("prev ie", 32'(prev_interrupt_enable), 32'(exp));
    endtask

    initial begin
        repeat (2000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        eic_pkg::eic_exc_kind_t k;
        logic [31:0] a;
        logic [3:0] fe;
        fe = 4'h0;
        a = 32'h0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rd(MISC, 32'h0);
        rd(FLT, 32'h0);
        rd(CFG, 32'h0);
        chk("ecc ignore", 32'(ecc_ignore), 32'h1);
        rd(5'h1f, 32'h0);
        $display("test reset finished");
        @(posedge ref_clk);
        ecc_error <= 1'b1;
        ecc_recoverable <= 1'b1;
        tlb_entry_tag <= 8'h9c;
        status_ie <= 1'b1;
        wr(CFG, 32'hf);
        rd(CFG, 32'hf);
        chk("protect", 32'(protection_on), 32'h1);
        chk("ecc ignore", 32'(ecc_ignore), 32'h0);
        chk("ecc exc", 32'(ecc_exception_req), 32'h1);
        chk("ecc fix", 32'(ecc_recover_req), 32'h1);
        wr(CFG, 32'h2);
        rd(CFG, 32'h2);
        chk("ecc exc", 32'(ecc_exception_req), 32'h0);
        irq(1'b0);
        wr(CFG, 32'h8);
        // live enable low, so only the nesting bit can hold it at one
        status_ie <= 1'b0;
        irq(1'b1);
        $display("test config finished");
        // same write carries tag 05, the entry tag must win
        wr(MISC, 32'h0008_0050);
        @(negedge ref_clk);
        chk("tlb req", 32'(tlb_read_req), 32'h1);
        rd(MISC, 32'h0000_09c0);
        wr(MISC, 32'h0000_0a5f);
        rd(MISC, 32'h0000_0a50);
        $display("test tlb finished");
        for (int i = 0; i < 13; i++) begin
            k = eic_pkg::eic_exc_kind_t'(i);
            a = 32'h8000_0010 + 32'(i);
            fe = FT[i] | ((i == 12) ? {3'h0, fe[0]} : 4'h0);
            ex(k, a);
            chk("flags", 32'(flags_out), 32'(fe));
            chk("fault", fault_address, a);
            rd(MISC, {20'h0, 8'ha5, fe});
        end
        wr(MISC, 32'h0000_0a50);
        rd(MISC, {20'h0, 8'ha5, fe});
        wr(FLT, 32'hffff_ffff);
        rd(FLT, a);
        $display("test exceptions finished");
        end_of_test();
    end
endmodule
